// ---- inc/ssp_map.vh ----
// Operation
// - Shift and count on falling serial clock
// - Eight-bit shift register, four-bit pulse counter
// - Bytes move most significant bit first
// - After eight pulses, further clocking is gated
// - Interrupt on eighth edge unless rewritten
// - Interrupt disarmed after reset
// - Data write arms, disable write disarms
// - Reset or data write clears counter
// - Master clock is software-toggled port line
// - Input pin input, output open-drain
// - Interrupt line one, falling option bit
// - Interrupt marks byte received or sent
// - Core may hold data and clock low
// - Input and output joined for two-wire
// - Start via input pin interrupt, poll stop
// - Slave stretches clock via open-drain zero
// - Software reads pin levels for comparison
// - Open-drain output routes shift register out
`ifndef SSP_MAP_VH
`define SSP_MAP_VH
// ==========================================================
// Register indices; the byte address is four times the index.
// ==========================================================
`define SSP_IDX_DATA 8'hdd
`define SSP_IDX_IDIS 8'hc2
`define SSP_IDX_IOR 8'hc8
`define SSP_IDX_PCTL 8'hd0
`define SSP_IDX_STAT 8'hd1
// ==========================================================
// Field positions.
// ==========================================================
`define SSP_IOR_EDGE_BIT 6
`define SSP_PCTL_CLK_DAT 0
`define SSP_PCTL_CLK_DIR 1
`define SSP_PCTL_CLK_OD 2
`define SSP_PCTL_OUT_DAT 3
`define SSP_PCTL_OUT_DIR 4
`define SSP_PCTL_OUT_OD 5
`define SSP_PCTL_SIN_IE 6
`define SSP_STAT_START_BIT 6
// ==========================================================
// Reset values and counts.
// ==========================================================
`define SSP_DATA_RST 8'h00
`define SSP_IOR_RST 8'h00
`define SSP_PCTL_RST 8'h00
`define SSP_BITS_PER_BYTE 4'h8
`endif

// ---- logic/ssp_top.v ----
// The APB interface to the registers is this design's own decision.
`include "ssp_map.vh"

// Serial shift port with an APB register slave.
module ssp_top (
   input wire pclk,
   input wire presetn,
   input wire psel,
   input wire penable,
   input wire pwrite,
   input wire [11:0] paddr,
   input wire [31:0] pwdata,
   output reg [31:0] prdata,
   output reg pready,
   output reg pslverr,
   input wire clk_port_line_i,
   output reg clk_port_line_o,
   output reg clk_port_line_oe,
   input wire input_port_line_i,
   output reg output_port_line_o,
   output reg output_port_line_oe,
   output reg xfer_irq,
   output reg sin_irq
);

   // ==========================================================
   // Storage.
   // ==========================================================
   reg [7:0] shift_reg; // Data and shift register.
   reg [3:0] count_reg; // Pulses seen in this byte.
   reg armed_reg; // Transfer interrupt enabled.
   reg pend_reg; // Latched transfer event.
   reg [7:0] ior_reg; // Interrupt option register.
   reg [7:0] pctl_reg; // Port direction and data bits.
   reg start_reg; // Falling edge seen on the input pin.
   reg [1:0] clk_sync_reg; // Clock pin synchroniser.
   reg [1:0] sin_sync_reg; // Input pin synchroniser.
   reg clk_prev_reg; // Last synchronised clock level.
   reg sin_prev_reg; // Last synchronised input level.

   wire clk_lvl = clk_sync_reg[1];
   wire sin_lvl = sin_sync_reg[1];
   // Terminal output of the counter, low once a byte is done.
   wire count_done_n = (count_reg != `SSP_BITS_PER_BYTE);
   wire fall = clk_prev_reg & ~clk_lvl;
   wire shift_en = fall & count_done_n;
   wire last_edge = shift_en & (count_reg == 4'h7);
   wire sin_fall = sin_prev_reg & ~sin_lvl;

   // ==========================================================
   // APB decode.
   // ==========================================================
   wire access = psel & penable;
   wire commit = access & pready; // Edge at which a transfer ends.
   wire [9:0] idx = paddr[11:2];
   wire wr = commit & pwrite;
   wire hit_data = (idx == {2'h0, `SSP_IDX_DATA});
   wire hit_idis = (idx == {2'h0, `SSP_IDX_IDIS});
   wire hit_ior = (idx == {2'h0, `SSP_IDX_IOR});
   wire hit_pctl = (idx == {2'h0, `SSP_IDX_PCTL});
   wire hit_stat = (idx == {2'h0, `SSP_IDX_STAT});
   wire mapped = hit_data | hit_idis | hit_ior | hit_pctl | hit_stat;
   wire wr_data = wr & hit_data;
   wire wr_idis = wr & hit_idis;
   reg [7:0] rd_val;

   // Read multiplexer; the disable location reads as zero.
   always @* begin
      rd_val = 8'h00;
      if (hit_data) begin
         rd_val = shift_reg;
      end else if (hit_ior) begin
         rd_val = ior_reg;
      end else if (hit_pctl) begin
         rd_val = pctl_reg;
      end else if (hit_stat) begin
         rd_val = {pend_reg, start_reg, count_reg, sin_lvl, clk_lvl};
      end
   end

   // ==========================================================
   // Bus answer: one wait state, then ready for one cycle.
   // ==========================================================
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         pslverr <= 1'b0;
         prdata <= 32'h00000000;
      end else begin
         pready <= access & ~pready;
         pslverr <= access & ~pready & ~mapped;
         if (access & ~pready & ~pwrite) begin
            prdata <= {24'h000000, rd_val};
         end
      end
   end

   // ==========================================================
   // Pin synchronisers; the first stage feeds only the second.
   // ==========================================================
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_sync_reg <= 2'b11;
         sin_sync_reg <= 2'b11;
         clk_prev_reg <= 1'b1;
         sin_prev_reg <= 1'b1;
      end else begin
         clk_sync_reg <= {clk_sync_reg[0], clk_port_line_i};
         sin_sync_reg <= {sin_sync_reg[0], input_port_line_i};
         clk_prev_reg <= clk_sync_reg[1];
         sin_prev_reg <= sin_sync_reg[1];
      end
   end

   // ==========================================================
   // Shift register and pulse counter.
   // ==========================================================
   // A processor write reloads the byte and restarts the count.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         shift_reg <= `SSP_DATA_RST;
         count_reg <= 4'h0;
      end else if (wr_data) begin
         shift_reg <= pwdata[7:0];
         count_reg <= 4'h0;
      end else if (shift_en) begin
         shift_reg <= {shift_reg[6:0], sin_lvl};
         count_reg <= count_reg + 4'h1;
      end
   end

   // ==========================================================
   // Transfer interrupt arming and pending event.
   // ==========================================================
   // A data write in the same cycle as the eighth edge wins.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         armed_reg <= 1'b0;
         pend_reg <= 1'b0;
      end else begin
         if (wr_data) begin
            armed_reg <= 1'b1;
         end else if (wr_idis) begin
            armed_reg <= 1'b0;
         end
         if (wr_data | wr_idis) begin
            pend_reg <= 1'b0;
         end else if (last_edge & armed_reg) begin
            pend_reg <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Option, port control and start flag registers.
   // ==========================================================
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ior_reg <= `SSP_IOR_RST;
         pctl_reg <= `SSP_PCTL_RST;
         start_reg <= 1'b0;
      end else begin
         if (wr & hit_ior) begin
            ior_reg <= pwdata[7:0];
         end
         if (wr & hit_pctl) begin
            pctl_reg <= pwdata[7:0];
         end
         // A new falling edge beats a clear in the same cycle.
         if (sin_fall & pctl_reg[`SSP_PCTL_SIN_IE]) begin
            start_reg <= 1'b1;
         end else if (wr & hit_stat & pwdata[`SSP_STAT_START_BIT]) begin
            start_reg <= 1'b0;
         end
      end
   end

   // ==========================================================
   // Pin drivers and interrupt lines.
   // ==========================================================
   // Clock pin: input, push-pull output, or open-drain output.
   // Data pin: shift output open-drain, push-pull port bit, or input.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_port_line_o <= 1'b0;
         clk_port_line_oe <= 1'b0;
         output_port_line_o <= 1'b0;
         output_port_line_oe <= 1'b0;
         xfer_irq <= 1'b0;
         sin_irq <= 1'b0;
      end else begin
         if (!pctl_reg[`SSP_PCTL_CLK_DIR]) begin
            clk_port_line_o <= 1'b0;
            clk_port_line_oe <= 1'b0;
         end else if (pctl_reg[`SSP_PCTL_CLK_OD]) begin
            clk_port_line_o <= 1'b0;
            clk_port_line_oe <= ~pctl_reg[`SSP_PCTL_CLK_DAT];
         end else begin
            clk_port_line_o <= pctl_reg[`SSP_PCTL_CLK_DAT];
            clk_port_line_oe <= 1'b1;
         end
         if (pctl_reg[`SSP_PCTL_OUT_OD]) begin
            output_port_line_o <= 1'b0;
            output_port_line_oe <= ~shift_reg[7];
         end else if (pctl_reg[`SSP_PCTL_OUT_DIR]) begin
            output_port_line_o <= pctl_reg[`SSP_PCTL_OUT_DAT];
            output_port_line_oe <= 1'b1;
         end else begin
            output_port_line_o <= 1'b0;
            output_port_line_oe <= 1'b0;
         end
         // Option bit clear: latched edge event; set: level of done.
         if (ior_reg[`SSP_IOR_EDGE_BIT]) begin
            xfer_irq <= armed_reg & ~count_done_n;
         end else begin
            xfer_irq <= pend_reg;
         end
         sin_irq <= start_reg;
      end
   end

endmodule

// ---- dv/ssp_assertions.sv ----
`include "ssp_map.vh"
module ssp_assertions (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic clk_port_line_i,
   input wire logic xfer_irq
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Helper state: falls seen since a data write, and their age.
   wire acc = psel & penable & pready;
   wire [9:0] idx = paddr[11:2];
   wire hi0 = idx[9:8] == 2'b00;
   wire is_dat = hi0 && idx[7:0] == `SSP_IDX_DATA;
   wire is_ids = hi0 && idx[7:0] == `SSP_IDX_IDIS;
   wire known = hi0 && (idx[7:0] inside {`SSP_IDX_DATA, `SSP_IDX_IDIS, `SSP_IDX_IOR, `SSP_IDX_PCTL, `SSP_IDX_STAT});
   logic clk_d, armed;
   logic [3:0] nfall, since;
   wire fall = clk_d & ~clk_port_line_i;
   // Counts raw pin falls; the raw count never lags the synced one unless a fall lands in a data-write cycle or the one before.
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         clk_d <= 1'b1;
         armed <= 1'b0;
         nfall <= 4'h0;
         since <= 4'hf;
      end else begin
         clk_d <= clk_port_line_i;
         if (acc && pwrite && is_dat) begin
            nfall <= 4'h0;
            armed <= 1'b1;
         end else if (fall && nfall != 4'hf) begin
            nfall <= nfall + 4'h1;
         end
         since <= fall ? 4'h0 : (since != 4'hf ? since + 4'h1 : since);
      end
   end
   default clocking @(posedge pclk); endclocking
   default disable iff (!presetn);
   acc_wait_a: assert property (psel && !penable |=> !pready ##1 pready)
      else $error("access answer not in third cycle");
   err_pair_a: assert property (pslverr |-> pready)
      else $error("error without ready");
   unmap_err_a: assert property (acc && !known |-> pslverr)
      else $error("unmapped access not refused");
   rd_upper_a: assert property (pready && !pwrite |-> prdata[31:8] == 24'h0)
      else $error("read data upper bits set");
   rst_quiet_a: assert property (!armed |-> !xfer_irq)
      else $error("interrupt before any arming write");
   idis_clear_a: assert property (acc && pwrite && is_ids |=> ##[0:2] !xfer_irq)
      else $error("disable write left interrupt up");
   dat_clear_a: assert property (acc && pwrite && is_dat |=> ##[0:2] !xfer_irq)
      else $error("data write left interrupt up");
   irq_count_a: assert property ($rose(xfer_irq) |-> nfall >= 4'h8)
      else $error("interrupt before eight falls");
   irq_edge_a: assert property ($rose(xfer_irq) |-> since < 4'hc)
      else $error("interrupt not tied to a clock fall");
endmodule
bind ssp_top ssp_assertions chk_u (.*);

// ---- dv/ssp_peer.sv ----
// External serial master: open-drain clock and data, idle released.
module ssp_peer (
   output logic scl,
   output logic sd_low,
   input wire logic sd
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      scl = 1'b1;
      sd_low = 1'b0;
   end
   // Clocks n bits MSB first at 160 ns, sampling the shared wire before each fall.
   task automatic xfer(input logic [7:0] tx, input int n, output logic [7:0] rx);
      rx = 8'h00;
      for (int i = 7; i > 7 - n; i--) begin
         sd_low = !tx[i];
         #40 rx[i] = sd;
         #40 scl = 1'b0;
         #80 scl = 1'b1;
      end
      sd_low = 1'b0;
   endtask
endmodule

// ---- dv/testbench.sv ----
`include "ssp_map.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   // ==========================================================
   // Signals, wired-AND pins with pull-ups, instances.
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, prdata, r;
   logic pready, pslverr, e, co, coe, oo, ooe, xfer_irq, sin_irq, scl, sdl;
   logic [7:0] rx;
   int n_mismatch = 0, n_checks = 0, cyc = 0;
   localparam logic [11:0] A_DAT = {2'b00, `SSP_IDX_DATA, 2'b00};
   localparam logic [11:0] A_IDS = {2'b00, `SSP_IDX_IDIS, 2'b00};
   localparam logic [11:0] A_IOR = {2'b00, `SSP_IDX_IOR, 2'b00};
   localparam logic [11:0] A_PCT = {2'b00, `SSP_IDX_PCTL, 2'b00};
   localparam logic [11:0] A_STA = {2'b00, `SSP_IDX_STAT, 2'b00};
   wire scl_w = scl & ~(coe & ~co);
   wire sd_w = ~sdl & ~(ooe & ~oo);
   ssp_top dut_u (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .clk_port_line_i(scl_w), .clk_port_line_o(co), .clk_port_line_oe(coe), .input_port_line_i(sd_w),
      .output_port_line_o(oo), .output_port_line_oe(ooe), .xfer_irq(xfer_irq), .sin_irq(sin_irq));
   ssp_peer peer_u (.scl(scl), .sd_low(sdl), .sd(sd_w));
   initial forever #4 pclk = ~pclk;
   // Cuts a hang short.
   always @(posedge pclk) begin
      cyc++;
      if (cyc == 5000) begin
         n_mismatch++;
         complete_run();
      end
   end
   task automatic complete_run();
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic chk(string n, logic [31:0] s, logic [31:0] x);
      n_checks++;
      if (s !== x) begin
         n_mismatch++;
         $display("ERROR %s expected %h seen %h", n, x, s);
      end
   endtask
   // One APB transfer; the request is held until pready is sampled high.
   task automatic apb(logic w, logic [11:0] a, logic [31:0] d, output logic [31:0] rd, output logic er);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wr(logic [11:0] a, logic [31:0] d);
      apb(1'b1, a, d, r, e);
   endtask
   // Lets pin changes pass the synchronisers before reading.
   task automatic rdchk(string n, logic [11:0] a, logic [31:0] x);
      repeat (4) @(posedge pclk);
      apb(1'b0, a, 32'h0, r, e);
      chk(n, r, x);
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      rdchk("data_rst", A_DAT, 32'h0);
      rdchk("stat_rst", A_STA, 32'h3);
      chk("irq_rst", 32'(xfer_irq), 32'h0);
      apb(1'b0, 12'h000, 32'h0, r, e);
      chk("unmapped", 32'(e), 32'h1);
      wr(A_IOR, 32'h40);
      rdchk("ior", A_IOR, 32'h40);
      wr(A_IOR, 32'h0);
      wr(A_PCT, 32'h30);
      wr(A_DAT, 32'ha5);
      peer_u.xfer(8'h3c, 8, rx);
      chk("rx1", 32'(rx), 32'h24);
      rdchk("shift", A_DAT, 32'h24);
      chk("irq8", 32'(xfer_irq), 32'h1);
      rdchk("stat8", A_STA, 32'ha1);
      peer_u.xfer(8'h00, 2, rx);
      rdchk("gated", A_DAT, 32'h24);
      wr(A_IDS, 32'h0);
      rdchk("idis_rd", A_IDS, 32'h0);
      chk("idis", 32'(xfer_irq), 32'h0);
      wr(A_DAT, 32'hff);
      peer_u.xfer(8'hff, 3, rx);
      rdchk("part", A_STA, 32'hf);
      wr(A_DAT, 32'h5a);
      rdchk("clr", A_STA, 32'h1);
      peer_u.xfer(8'hff, 8, rx);
      chk("rx2", 32'(rx), 32'h5a);
      chk("irq2", 32'(xfer_irq), 32'h1);
      wr(A_DAT, 32'h81);
      wr(A_IDS, 32'h0);
      peer_u.xfer(8'hff, 8, rx);
      rdchk("nopend", A_STA, 32'h23);
      chk("noirq", 32'(xfer_irq), 32'h0);
      complete_run();
   end
endmodule
